//--- design/mac_pkg.sv
// shared widths, field positions and reset values of the 16x16 mac
package mac_pkg;

    // operand and product half width
    localparam int unsigned OPERAND_WIDTH = 16;
    // extension bits above the upper product half
    localparam int unsigned EXT_WIDTH     = 3;
    // full accumulator: extension, upper half, lower half
    localparam int unsigned ACC_WIDTH     = 2 * OPERAND_WIDTH + EXT_WIDTH;
    // rounding adds one at the top bit of the lower half
    localparam int unsigned ROUND_BIT     = 15;

    // field positions inside the accumulator
    localparam int unsigned LOWER_LSB     = 0;
    localparam int unsigned UPPER_LSB     = 16;
    localparam int unsigned EXT_LSB       = 32;

    // positions inside the synchronised control vector
    localparam int unsigned CTL_X_CLK     = 0;
    localparam int unsigned CTL_Y_CLK     = 1;
    localparam int unsigned CTL_P_CLK     = 2;
    localparam int unsigned CTL_ROUND     = 3;
    localparam int unsigned CTL_ACCUM     = 4;
    localparam int unsigned CTL_SUB       = 5;
    localparam int unsigned CTL_SIGNED    = 6;
    localparam int unsigned CTL_PRELOAD   = 7;
    localparam int unsigned CTL_UPPER_OEN = 8;
    localparam int unsigned CTL_LOWER_OEN = 9;
    localparam int unsigned CTL_EXT_OEN   = 10;
    localparam int unsigned CTL_WIDTH     = 11;

    // reset values
    localparam logic [15:0] OPERAND_RESET = 16'h0000;
    localparam logic [34:0] ACC_RESET     = 35'h0_0000_0000;

endpackage

//--- design/mac_pin_sync.sv
// two-stage pin synchroniser with rising edge detect per bit
`timescale 1ns/1ps

module mac_pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_arst_n,
    input  wire logic [WIDTH-1:0] i_pin,
    output logic      [WIDTH-1:0] o_level,
    output logic      [WIDTH-1:0] o_rise
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
        logic [WIDTH-1:0] prev;
    } mac_sync_state_t;

    mac_sync_state_t state_reg;
    mac_sync_state_t state_next;

    ////////////////////////////////////////////////////////////////////////
    // first stage feeds only the second stage
    always_comb
    begin
        state_next        = state_reg;
        state_next.meta   = i_pin;
        state_next.stable = state_reg.meta;
        state_next.prev   = state_reg.stable;
    end

    // constants only under reset
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // edge seen on the settled stages, aligned with the data stage
    assign o_level = state_reg.stable;
    assign o_rise  = state_reg.stable & ~state_reg.prev;

endmodule

//--- design/mac_arith.sv
// combinational multiply, round and accumulate datapath
`timescale 1ns/1ps

module mac_arith (
    input  wire logic [15:0] i_x_operand,
    input  wire logic [15:0] i_y_operand,
    input  wire logic [34:0] i_acc,
    input  wire logic        i_round_control,
    input  wire logic        i_accumulate_select,
    input  wire logic        i_subtract_select,
    input  wire logic        i_signed_format_select,
    output logic      [34:0] o_result
);

    logic signed [16:0] x_ext;
    logic signed [16:0] y_ext;
    logic signed [33:0] product;
    logic        [34:0] product_wide;
    logic        [34:0] round_term;

    ////////////////////////////////////////////////////////////////////////
    // a seventeenth bit carries the sign only in signed format
    assign x_ext = {i_x_operand[15] & i_signed_format_select,
                    i_x_operand};
    assign y_ext = {i_y_operand[15] & i_signed_format_select,
                    i_y_operand};
    assign product = x_ext * y_ext;
    assign product_wide = {product[33], product};

    // round at the top bit of the lower half
    assign round_term = i_round_control
                      ? (35'h0_0000_0001 << mac_pkg::ROUND_BIT)
                      : 35'h0_0000_0000;

    ////////////////////////////////////////////////////////////////////////
    // subtract is ignored unless accumulating
    always_comb
    begin
        if (!i_accumulate_select)
            o_result = product_wide + round_term;
        else if (i_subtract_select)
            o_result = i_acc - product_wide + round_term;
        else
            o_result = i_acc + product_wide + round_term;
    end

endmodule

//--- design/mac_top.sv
// 16x16 multiplier-accumulator with shared lower-half / y bus
`timescale 1ns/1ps

module mac_top (
    input  wire logic        i_core_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_x_clk_pin,
    input  wire logic        i_y_clk_pin,
    input  wire logic        i_product_clk_pin,
    input  wire logic [15:0] i_x_operand,
    input  wire logic        i_round_control,
    input  wire logic        i_accumulate_select,
    input  wire logic        i_subtract_select,
    input  wire logic        i_signed_format_select,
    input  wire logic        i_preload,
    input  wire logic        i_upper_out_en_n,
    input  wire logic        i_lower_out_en_n,
    input  wire logic        i_ext_out_en_n,
    input  wire logic [15:0] i_upper_product_half,
    output logic      [15:0] o_upper_product_half,
    output logic             o_upper_product_half_oe,
    input  wire logic [15:0] i_lower_product_half,
    output logic      [15:0] o_lower_product_half,
    output logic             o_lower_product_half_oe,
    input  wire logic [2:0]  i_ext_product,
    output logic      [2:0]  o_ext_product,
    output logic             o_ext_product_oe
);

    typedef struct packed {
        logic [15:0] x_operand;
        logic [15:0] y_operand;
        logic        round_control;
        logic        accumulate_select;
        logic        subtract_select;
        logic        signed_format_select;
        logic [34:0] acc;
    } mac_top_state_t;

    localparam int unsigned DATA_WIDTH = 51;

    mac_top_state_t state_reg;
    mac_top_state_t state_next;

    logic [mac_pkg::CTL_WIDTH-1:0] ctl_pins;
    logic [mac_pkg::CTL_WIDTH-1:0] ctl_level;
    logic [mac_pkg::CTL_WIDTH-1:0] ctl_rise;
    logic [DATA_WIDTH-1:0]         data_pins;
    logic [DATA_WIDTH-1:0]         data_level;
    logic [15:0]                   x_sync;
    logic [15:0]                   y_sync;
    logic [15:0]                   upper_sync;
    logic [2:0]                    ext_sync;
    logic [34:0]                   mac_result;
    logic                          x_edge;
    logic                          y_edge;
    logic                          p_edge;
    logic                          upper_on;
    logic                          lower_on;
    logic                          ext_on;

    ////////////////////////////////////////////////////////////////////////
    // every pin passes two flops; clocks and data share latency so data
    // seen with a clock edge is the value present at that edge
    assign ctl_pins = {i_ext_out_en_n, i_lower_out_en_n, i_upper_out_en_n,
                       i_preload, i_signed_format_select, i_subtract_select,
                       i_accumulate_select, i_round_control,
                       i_product_clk_pin, i_y_clk_pin, i_x_clk_pin};
    assign data_pins = {i_ext_product, i_upper_product_half,
                        i_lower_product_half, i_x_operand};

    mac_pin_sync #(
        .WIDTH (mac_pkg::CTL_WIDTH)
    ) u_ctl_sync (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_pin      (ctl_pins),
        .o_level    (ctl_level),
        .o_rise     (ctl_rise)
    );

    mac_pin_sync #(
        .WIDTH (DATA_WIDTH)
    ) u_data_sync (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_pin      (data_pins),
        .o_level    (data_level),
        .o_rise     ()
    );

    // data words are taken as levels, never edge-timed
    assign x_sync     = data_level[15:0];
    assign y_sync     = data_level[31:16];
    assign upper_sync = data_level[47:32];
    assign ext_sync   = data_level[50:48];

    assign x_edge = ctl_rise[mac_pkg::CTL_X_CLK];
    assign y_edge = ctl_rise[mac_pkg::CTL_Y_CLK];
    assign p_edge = ctl_rise[mac_pkg::CTL_P_CLK];

    // enables are active low at the pins
    assign upper_on = ~ctl_level[mac_pkg::CTL_UPPER_OEN];
    assign lower_on = ~ctl_level[mac_pkg::CTL_LOWER_OEN];
    assign ext_on   = ~ctl_level[mac_pkg::CTL_EXT_OEN];

    ////////////////////////////////////////////////////////////////////////
    // arithmetic works on the registered operands and modes
    mac_arith u_arith (
        .i_x_operand            (state_reg.x_operand),
        .i_y_operand            (state_reg.y_operand),
        .i_acc                  (state_reg.acc),
        .i_round_control        (state_reg.round_control),
        .i_accumulate_select    (state_reg.accumulate_select),
        .i_subtract_select      (state_reg.subtract_select),
        .i_signed_format_select (state_reg.signed_format_select),
        .o_result               (mac_result)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state: operand clocks, then product clock
    always_comb
    begin
        state_next = state_reg;
        // each operand register follows only its own clock
        if (x_edge)
            state_next.x_operand = x_sync;
        if (y_edge)
            state_next.y_operand = y_sync;
        // modes ride in with either operand clock
        if (x_edge || y_edge)
        begin
            state_next.round_control =
                ctl_level[mac_pkg::CTL_ROUND];
            state_next.accumulate_select =
                ctl_level[mac_pkg::CTL_ACCUM];
            state_next.subtract_select =
                ctl_level[mac_pkg::CTL_SUB];
            state_next.signed_format_select =
                ctl_level[mac_pkg::CTL_SIGNED];
        end
        // accumulator moves only on a product clock edge
        if (p_edge)
        begin
            if (ctl_level[mac_pkg::CTL_PRELOAD])
            begin
                // a driven register keeps its value: its pins echo us
                if (!upper_on)
                    state_next.acc[31:16] = upper_sync;
                if (!lower_on)
                    state_next.acc[15:0] = y_sync;
                if (!ext_on)
                    state_next.acc[34:32] = ext_sync;
            end
            else
            begin
                state_next.acc = mac_result;
            end
        end
    end

    // constants only under reset
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_reg                      <= '0;
            state_reg.x_operand            <= mac_pkg::OPERAND_RESET;
            state_reg.y_operand            <= mac_pkg::OPERAND_RESET;
            state_reg.acc                  <= mac_pkg::ACC_RESET;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs: data straight from the accumulator flops
    assign o_upper_product_half = state_reg.acc[31:16];
    assign o_lower_product_half = state_reg.acc[15:0];
    assign o_ext_product        = state_reg.acc[34:32];

    // release each bus independently; host avoids overlap with y drive
    assign o_upper_product_half_oe = upper_on;
    assign o_lower_product_half_oe = lower_on;
    assign o_ext_product_oe        = ext_on;

endmodule

//--- sim/mac_top_props.sv
// checker: enable and hold relations at the mac top ports
`timescale 1ns/1ps
module mac_top_props (
    input wire logic        i_core_clk,
    input wire logic        i_arst_n,
    input wire logic        i_product_clk_pin,
    input wire logic        i_preload,
    input wire logic        i_upper_out_en_n,
    input wire logic        i_lower_out_en_n,
    input wire logic        i_ext_out_en_n,
    input wire logic [15:0] o_upper_product_half,
    input wire logic        o_upper_product_half_oe,
    input wire logic [15:0] o_lower_product_half,
    input wire logic        o_lower_product_half_oe,
    input wire logic [2:0]  o_ext_product,
    input wire logic        o_ext_product_oe
);
    logic       prev_reg;
    logic [7:0] hist_reg;
    logic [1:0] age_reg;
    ////////////////////////////////////////
    // product pin rises seen lately; age masks synchroniser flush
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            prev_reg <= 1'b0;
            hist_reg <= 8'h00;
            age_reg <= 2'h0;
        end
        else
        begin
            prev_reg <= i_product_clk_pin;
            hist_reg <= {hist_reg[6:0], i_product_clk_pin & ~prev_reg};
            age_reg <= (age_reg == 2'h3) ? age_reg : age_reg + 2'h1;
        end
    end
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    ////////////////////////////////////////
    // enables reach the oe outputs within a few edges
    oe_upper_a: assert property ((age_reg == 2'h3 &&
        $stable(i_upper_out_en_n)) [*3] |->
        o_upper_product_half_oe == !i_upper_out_en_n) else $error("upper oe");
    upper_off_a: assert property ($rose(i_upper_out_en_n) |->
        ##[1:4] !o_upper_product_half_oe) else $error("upper oe stuck");
    oe_lower_a: assert property ($fell(i_lower_out_en_n) &&
        age_reg == 2'h3 |-> ##[1:4] o_lower_product_half_oe)
        else $error("lower oe late");
    oe_ext_a: assert property ($rose(i_ext_out_en_n) |->
        ##[1:4] !o_ext_product_oe) else $error("ext oe stuck");
    // results move only after a product clock rise
    upper_hold_a: assert property ($changed(o_upper_product_half) |->
        |hist_reg) else $error("upper moved without clock");
    lower_hold_a: assert property (!(|hist_reg) |->
        $stable(o_lower_product_half)) else $error("lower moved");
    ext_hold_a: assert property ((!i_product_clk_pin) [*8] |->
        $stable(o_ext_product)) else $error("ext moved");
    preload_keep_a: assert property ((i_preload &&
        !i_upper_out_en_n) [*6] |-> $stable(o_upper_product_half))
        else $error("enabled half preloaded");
    cover property ($rose(i_product_clk_pin) && i_preload);
    cover property ($rose(o_lower_product_half_oe));
    cover property ($rose(i_product_clk_pin) && !i_preload);
endmodule

bind mac_top mac_top_props u_props (
    .i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
    .i_product_clk_pin(i_product_clk_pin), .i_preload(i_preload),
    .i_upper_out_en_n(i_upper_out_en_n),
    .i_lower_out_en_n(i_lower_out_en_n), .i_ext_out_en_n(i_ext_out_en_n),
    .o_upper_product_half(o_upper_product_half),
    .o_upper_product_half_oe(o_upper_product_half_oe),
    .o_lower_product_half(o_lower_product_half),
    .o_lower_product_half_oe(o_lower_product_half_oe),
    .o_ext_product(o_ext_product), .o_ext_product_oe(o_ext_product_oe));

//--- sim/mac_host_bus.sv
// host side of one shared three-state bus: resolves the wire level
`timescale 1ns/1ps
module mac_host_bus #(
    parameter int unsigned W = 16
) (
    input  wire logic         i_core_clk,
    input  wire logic         i_host_drive,
    input  wire logic [W-1:0] i_host_data,
    input  wire logic         i_dev_oe,
    input  wire logic [W-1:0] i_dev_data,
    output logic      [W-1:0] o_wire,
    output logic              o_clash
);
    logic [W-1:0] last_reg = '0;
    logic         clash_reg = 1'b0;
    ////////////////////////////////////////
    // a floating wire toggles, so stale data can never pass as fresh
    assign o_wire = i_dev_oe ? i_dev_data
                  : i_host_drive ? i_host_data : ~last_reg;
    // sticky flag when both parties drive together
    assign o_clash = clash_reg;
    always @(posedge i_core_clk)
    begin
        last_reg <= o_wire;
        if (i_host_drive && i_dev_oe)
            clash_reg <= 1'b1;
    end
endmodule

//--- sim/mac_top_test.sv
// self-checking bench of the mac top: table rows, then hand cases
`timescale 1ns/1ps
module mac_top_test;
    // operands, modes {round, accumulate, subtract, signed}, result
    typedef struct packed {
        logic [15:0] x;
        logic [15:0] y;
        logic [3:0]  m;
        logic [34:0] r;
    } mac_row_t;
    mac_row_t rows [10] = '{
        '{16'h0003, 16'h0005, 4'h0, 35'h0_0000_000f},
        '{16'hffff, 16'hffff, 4'h0, 35'h0_fffe_0001},
        '{16'hffff, 16'hffff, 4'h4, 35'h1_fffc_0002},
        '{16'hffff, 16'hffff, 4'h1, 35'h0_0000_0001},
        '{16'hffff, 16'h0002, 4'h1, 35'h7_ffff_fffe},
        '{16'h0001, 16'h0003, 4'h5, 35'h0_0000_0001},
        '{16'h0002, 16'h0002, 4'h6, 35'h7_ffff_fffd},
        '{16'h0002, 16'h0003, 4'h2, 35'h0_0000_0006},
        '{16'h0001, 16'h8000, 4'h8, 35'h0_0001_0000},
        '{16'h8000, 16'h8000, 4'h9, 35'h0_4000_8000}};
    logic clk = 0, rst_n = 0, xck = 0, yck = 0, pck = 0, pre = 0;
    logic rnd = 0, acc = 0, sub = 0, sgn = 0, ue_n = 1, le_n = 1, ee_n = 1;
    logic hu_d = 0, hl_d = 0, he_d = 0, ou_oe, ol_oe, oe_oe, cu, cl, ce;
    logic [15:0] x_op = 0, hu = 0, hl = 0, ou, ol, wu, wl;
    logic [2:0]  he = 0, oe3, we;
    int failures = 0, compares = 0;
    ////////////////////////////////////////
    always #10 clk = ~clk;
    mac_top dut (.i_core_clk(clk), .i_arst_n(rst_n), .i_x_clk_pin(xck),
        .i_y_clk_pin(yck), .i_product_clk_pin(pck), .i_x_operand(x_op),
        .i_round_control(rnd), .i_accumulate_select(acc),
        .i_subtract_select(sub), .i_signed_format_select(sgn),
        .i_preload(pre), .i_upper_out_en_n(ue_n), .i_lower_out_en_n(le_n),
        .i_ext_out_en_n(ee_n), .i_upper_product_half(wu),
        .o_upper_product_half(ou), .o_upper_product_half_oe(ou_oe),
        .i_lower_product_half(wl), .o_lower_product_half(ol),
        .o_lower_product_half_oe(ol_oe), .i_ext_product(we),
        .o_ext_product(oe3), .o_ext_product_oe(oe_oe));
    mac_host_bus #(.W(16)) bus_u (.i_core_clk(clk), .i_host_drive(hu_d),
        .i_host_data(hu), .i_dev_oe(ou_oe), .i_dev_data(ou), .o_wire(wu),
        .o_clash(cu));
    mac_host_bus #(.W(16)) bus_l (.i_core_clk(clk), .i_host_drive(hl_d),
        .i_host_data(hl), .i_dev_oe(ol_oe), .i_dev_data(ol), .o_wire(wl),
        .o_clash(cl));
    mac_host_bus #(.W(3)) bus_e (.i_core_clk(clk), .i_host_drive(he_d),
        .i_host_data(he), .i_dev_oe(oe_oe), .i_dev_data(oe3), .o_wire(we),
        .o_clash(ce));
    task automatic check(input string nm, input logic [34:0] seen, want);
    begin
        compares++;
        if (seen !== want)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, want, seen);
        end
    end
    endtask
    // operand load: pins held well past the synchroniser on both sides
    task automatic op(input logic [15:0] x, y, input logic [3:0] m,
                      input logic [1:0] ck);
    begin
        @(posedge clk);
        x_op <= x;
        hl <= y;
        hl_d <= 1'b1;
        {rnd, acc, sub, sgn} <= m;
        @(posedge clk);
        {yck, xck} <= ck;
        repeat (3) @(posedge clk);
        {yck, xck} <= 2'b00;
        repeat (3) @(posedge clk);
        hl_d <= 1'b0;
    end
    endtask
    task automatic prod();
    begin
        @(posedge clk);
        pck <= 1'b1;
        repeat (3) @(posedge clk);
        pck <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
    end
    endtask
    task automatic report_and_stop();
    begin
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge clk);
        check("reset", {oe3, ou, ol}, 35'h0);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        foreach (rows[i])
        begin
            op(rows[i].x, rows[i].y, rows[i].m, 2'b11);
            prod();
            check("row", {oe3, ou, ol}, rows[i].r);
        end
        $display("done: table");
        op(16'h0004, 16'h7777, 4'h0, 2'b01);
        prod();
        check("x only", {oe3, ou, ol}, 35'h0_0002_0000);
        op(16'h0000, 16'h0002, 4'h0, 2'b10);
        prod();
        check("y only", {oe3, ou, ol}, 35'h8);
        @(posedge clk);
        {hu_d, hl_d, he_d, pre} <= 4'hf;
        {hu, hl, he} <= {16'h1234, 16'h5678, 3'h3};
        prod();
        check("preload", {oe3, ou, ol}, 35'h3_1234_5678);
        // upper enabled: it must keep its value while the rest load
        @(posedge clk);
        {hu_d, ue_n} <= 2'b00;
        {hl, he} <= {16'h0001, 3'h0};
        repeat (4) @(posedge clk);
        prod();
        check("part preload", {oe3, ou, ol}, 35'h0_1234_0001);
        @(posedge clk);
        {hl_d, he_d, pre} <= 3'b000;
        op(16'h0001, 16'h0001, 4'h4, 2'b11);
        prod();
        check("acc on preload", {oe3, ou, ol}, 35'h0_1234_0002);
        @(posedge clk);
        {ue_n, le_n, ee_n} <= 3'b100;
        repeat (4) @(posedge clk);
        #1;
        check("lower bus", wl, 16'h0002);
        check("enables", {ou_oe, ol_oe, oe_oe}, 3'b011);
        @(posedge clk);
        {le_n, ee_n} <= 2'b11;
        repeat (5) @(posedge clk);
        #1;
        check("clash", {cu, cl, ce}, 3'b000);
        // reset in mid-run: accumulator clears, enables flush off again
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        check("mid reset", {oe3, ou, ol}, 35'h0);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        check("after reset", {ou_oe, ol_oe, oe_oe}, 3'b000);
        op(16'h0003, 16'h0003, 4'h4, 2'b11);
        prod();
        check("acc from zero", {oe3, ou, ol}, 35'h9);
        $display("done: hand cases");
        report_and_stop();
    end
    initial
    begin
        repeat (4000) @(posedge clk);
        failures++;
        $display("BAD watchdog expected end seen hang");
        report_and_stop();
    end
endmodule
